//--- pmr_result_regs.sv
/*
  Configuration, conversion sequencing, averaging and result registers of
  a shunt current, bus voltage and power monitor.
  Assumes the serial port logic presents register reads and writes as
  one-cycle strobes on ref_clk, and that the converter front end presents
  a settled sample on the same clock when a take strobe is issued.
*/
// Behaviour
// - Shunt conversion time field at bits 5:3 selects 140 us to 8.244 ms.
// - Mode field bits 2:0 resets to continuous shunt and bus measurement.
// - Mode 000/100 power-down; low bits pick inputs; top bit continuous.
// - Shunt result at pointer 01h, signed two's complement, read-only.
// - Shunt count weighs 2.5 uV; 7FFF is 81.9175 mV full scale.
// - Averaged values, not single samples, appear in all results.
// - Bus result at pointer 02h, unsigned, bit 15 always reads zero.
// - Bus count weighs 1.25 mV; 7FFF is 40.95875 V full scale.
// - Power result at pointer 03h; one count is 25 current counts.
// - Power is current magnitude times bus result with fixed weighting.
// - Current result at pointer 04h is shunt result times calibration.
// - Calibration at pointer 05h is read/write and sets result weights.
// - Calibration resets to zero so current and power read zero.
// - Configuration write halts conversion, then restarts with new values.
// - Averaging field bits 11:9 selects 1 to 1024 samples.
`timescale 1ns/100ps
module pmr_result_regs #(
  parameter int CONV_CYC [8] = pmr_pkg::CONV_CYC_DFLT,
  parameter int CUR_SHIFT    = pmr_pkg::CUR_SHIFT_DFLT
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Register access from the serial port logic
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Converter front end
  input  wire logic [15:0] shunt_sample,
  input  wire logic [14:0] bus_sample,
  output logic             shunt_take,
  output logic             bus_take,
  // Status
  output logic             results_update,
  output logic             conv_busy
);

  logic [15:0]                      config_reg;
  logic [15:0]                      scaling_calibration_reg;
  logic [15:0]                      shunt_voltage_result_reg;
  logic [15:0]                      bus_voltage_result_reg;
  logic [15:0]                      current_result;
  logic [15:0]                      power_result;
  logic                             soft_rst_reg;
  logic                             restart_reg;
  logic                             calc_go_reg;
  pmr_pkg::pmr_state_t              state_reg;
  pmr_pkg::pmr_state_t              first_state;
  logic [pmr_pkg::TIMER_W-1:0]      timer_reg;
  logic [pmr_pkg::TIMER_W-1:0]      first_timer;
  logic [pmr_pkg::TIMER_W-1:0]      sh_cycles;
  logic [pmr_pkg::TIMER_W-1:0]      bus_cycles;
  logic [pmr_pkg::AVG_CNT_W-1:0]    set_cnt_reg;
  logic [pmr_pkg::AVG_CNT_W-1:0]    avg_last;
  logic [3:0]                       avg_sh;
  logic [pmr_pkg::SHUNT_ACC_W-1:0]  shunt_acc_reg;
  logic [pmr_pkg::SHUNT_ACC_W-1:0]  shunt_sum;
  logic [pmr_pkg::BUS_ACC_W-1:0]    bus_acc_reg;
  logic [pmr_pkg::BUS_ACC_W-1:0]    bus_sum;
  logic [2:0]                       op_mode;
  logic [2:0]                       shunt_conv_time;
  logic [2:0]                       rail_conv_time;
  logic [2:0]                       sample_average_count;
  logic                             op_select_hi;
  logic                             op_select_mid;
  logic                             op_select_lo;
  logic                             cfg_write;
  logic                             cal_write;
  logic                             halt;
  logic                             timer_done;
  logic                             seq_end;
  logic                             last_set;

  // Converts an averaging code into its shift amount.
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    avg_shift = 4'(pmr_pkg::AVG_SHIFT[code]);
  endfunction

  // Converts a conversion time code into a timer load value.
  function automatic logic [pmr_pkg::TIMER_W-1:0] conv_load(
    input logic [2:0] code
  );
    conv_load = pmr_pkg::TIMER_W'(CONV_CYC[code] - 1);
  endfunction

  // Configuration field decode.
  always_comb begin
    shunt_conv_time      = config_reg[pmr_pkg::CFG_SHCT_LSB +: 3];
    rail_conv_time       = config_reg[pmr_pkg::CFG_BUSCT_LSB +: 3];
    sample_average_count = config_reg[pmr_pkg::CFG_AVG_LSB +: 3];
    op_mode              = config_reg[pmr_pkg::CFG_MODE_LSB +: 3];
    op_select_hi         = op_mode[2];
    op_select_mid        = op_mode[1];
    op_select_lo         = op_mode[0];
  end

  assign cfg_write = reg_wr && (reg_addr == pmr_pkg::ADDR_CONFIG);
  assign cal_write = reg_wr && (reg_addr == pmr_pkg::ADDR_CAL);

  // Configuration register; bit 15 requests a full soft reset.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      config_reg   <= pmr_pkg::CFG_RESET;
      soft_rst_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      config_reg   <= pmr_pkg::CFG_RESET;
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= cfg_write && reg_wdata[pmr_pkg::CFG_RST_BIT];
      if (cfg_write) begin
        config_reg <= (reg_wdata & pmr_pkg::CFG_WR_MASK) |
                      pmr_pkg::CFG_RO_BITS;
      end
    end
  end

  // Calibration register; its top bit never stores.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scaling_calibration_reg <= pmr_pkg::CAL_RESET;
    end else if (soft_rst_reg) begin
      scaling_calibration_reg <= pmr_pkg::CAL_RESET;
    end else if (cal_write) begin
      scaling_calibration_reg <= reg_wdata & pmr_pkg::CAL_MASK;
    end
  end

  // A configuration write stops the sequence; the next cycle restarts it.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= cfg_write || soft_rst_reg;
    end
  end

  assign halt = cfg_write || soft_rst_reg;

  // Entry point of a measurement set for the current mode.
  always_comb begin
    sh_cycles  = conv_load(shunt_conv_time);
    bus_cycles = conv_load(rail_conv_time);
    if (op_select_lo) begin
      first_state = pmr_pkg::ST_SHUNT;
      first_timer = sh_cycles;
    end else if (op_select_mid) begin
      first_state = pmr_pkg::ST_BUS;
      first_timer = bus_cycles;
    end else begin
      first_state = pmr_pkg::ST_IDLE;
      first_timer = '0;
    end
  end

  assign avg_sh     = avg_shift(sample_average_count);
  assign avg_last   = pmr_pkg::AVG_CNT_W'((1 << avg_sh) - 1);
  assign timer_done = (timer_reg == '0);
  assign shunt_take = (state_reg == pmr_pkg::ST_SHUNT) && timer_done &&
                      !halt && !restart_reg;
  assign bus_take   = (state_reg == pmr_pkg::ST_BUS) && timer_done &&
                      !halt && !restart_reg;
  assign seq_end    = bus_take || (shunt_take && !op_select_mid);
  assign last_set   = seq_end && (set_cnt_reg == avg_last);
  assign conv_busy  = (state_reg != pmr_pkg::ST_IDLE);

  // Conversion sequencer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= pmr_pkg::ST_IDLE;
      timer_reg   <= '0;
      set_cnt_reg <= '0;
    end else if (halt) begin
      state_reg   <= pmr_pkg::ST_IDLE;
      timer_reg   <= '0;
      set_cnt_reg <= '0;
    end else if (restart_reg) begin
      state_reg   <= first_state;
      timer_reg   <= first_timer;
      set_cnt_reg <= '0;
    end else begin
      case (state_reg)
        pmr_pkg::ST_SHUNT: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (op_select_mid) begin
            state_reg <= pmr_pkg::ST_BUS;
            timer_reg <= bus_cycles;
          end
        end
        pmr_pkg::ST_BUS: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          timer_reg <= '0;
        end
      endcase
      if (seq_end) begin
        if (!last_set) begin
          set_cnt_reg <= set_cnt_reg + 1'b1;
          state_reg   <= first_state;
          timer_reg   <= first_timer;
        end else if (op_select_hi) begin
          set_cnt_reg <= '0;
          state_reg   <= first_state;
          timer_reg   <= first_timer;
        end else begin
          set_cnt_reg <= '0;
          state_reg   <= pmr_pkg::ST_IDLE;
          timer_reg   <= '0;
        end
      end
    end
  end

  // Running sums including a sample being taken this cycle.
  always_comb begin
    shunt_sum = shunt_acc_reg;
    bus_sum   = bus_acc_reg;
    if (shunt_take) begin
      shunt_sum = shunt_acc_reg +
        {{(pmr_pkg::SHUNT_ACC_W - 16){shunt_sample[15]}}, shunt_sample};
    end
    if (bus_take) begin
      bus_sum = bus_acc_reg +
        {{(pmr_pkg::BUS_ACC_W - 15){1'b0}}, bus_sample};
    end
  end

  // Sample accumulators, cleared at each restart and after each average.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shunt_acc_reg <= '0;
      bus_acc_reg   <= '0;
    end else if (halt || restart_reg || last_set) begin
      shunt_acc_reg <= '0;
      bus_acc_reg   <= '0;
    end else begin
      shunt_acc_reg <= shunt_sum;
      bus_acc_reg   <= bus_sum;
    end
  end

  // Measurement results, written once per completed average.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shunt_voltage_result_reg <= pmr_pkg::RESULT_RESET;
      bus_voltage_result_reg   <= pmr_pkg::RESULT_RESET;
      calc_go_reg              <= 1'b0;
    end else if (soft_rst_reg) begin
      shunt_voltage_result_reg <= pmr_pkg::RESULT_RESET;
      bus_voltage_result_reg   <= pmr_pkg::RESULT_RESET;
      calc_go_reg              <= 1'b0;
    end else begin
      calc_go_reg <= last_set;
      if (last_set && op_select_lo) begin
        // Signed average keeps the 2.5 uV weight per count.
        shunt_voltage_result_reg <=
          16'($signed(shunt_sum) >>> avg_sh);
      end
      if (last_set && op_select_mid) begin
        // Unsigned average keeps the 1.25 mV weight per count.
        bus_voltage_result_reg <=
          {1'b0, 15'(bus_sum >> avg_sh)};
      end
    end
  end

  assign results_update = calc_go_reg;

  pmr_result_math #(
    .CUR_SHIFT (CUR_SHIFT)
  ) u_math (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .soft_clr  (soft_rst_reg),
    .calc_go   (calc_go_reg),
    .shunt_avg (shunt_voltage_result_reg),
    .bus_avg   (bus_voltage_result_reg[14:0]),
    .cal_val   (scaling_calibration_reg[14:0]),
    .current_q (current_result),
    .power_q   (power_result)
  );

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= pmr_pkg::RDATA_NONE;
    end else if (reg_rd) begin
      if (reg_addr == pmr_pkg::ADDR_CONFIG) begin
        reg_rdata <= config_reg;
      end else if (reg_addr == pmr_pkg::ADDR_SHUNT) begin
        reg_rdata <= shunt_voltage_result_reg;
      end else if (reg_addr == pmr_pkg::ADDR_BUS) begin
        reg_rdata <= bus_voltage_result_reg;
      end else if (reg_addr == pmr_pkg::ADDR_POWER) begin
        reg_rdata <= power_result;
      end else if (reg_addr == pmr_pkg::ADDR_CURRENT) begin
        reg_rdata <= current_result;
      end else if (reg_addr == pmr_pkg::ADDR_CAL) begin
        reg_rdata <= scaling_calibration_reg;
      end else begin
        reg_rdata <= pmr_pkg::RDATA_NONE;
      end
    end
  end

endmodule

//--- pmr_pkg.sv
/*
  Shared constants and types of the power monitor result register block:
  register pointers, configuration field layout, reset values, conversion
  timing and averaging tables, and the fixed scaling between results.
  Assumes a 100 MHz device clock; nothing else is needed from outside.
*/
package pmr_pkg;

  // Register pointers.
  localparam logic [7:0] ADDR_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_SHUNT   = 8'h01;
  localparam logic [7:0] ADDR_BUS     = 8'h02;
  localparam logic [7:0] ADDR_POWER   = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_CAL     = 8'h05;

  // Configuration field positions.
  localparam int CFG_RST_BIT   = 15;
  localparam int CFG_AVG_LSB   = 9;
  localparam int CFG_BUSCT_LSB = 6;
  localparam int CFG_SHCT_LSB  = 3;
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_FIELD_W   = 3;

  // Reset values and masks.
  localparam logic [15:0] CFG_RESET    = 16'h4127;
  localparam logic [15:0] CFG_WR_MASK  = 16'h0FFF;
  localparam logic [15:0] CFG_RO_BITS  = 16'h4000;
  localparam logic [15:0] CAL_RESET    = 16'h0000;
  localparam logic [15:0] CAL_MASK     = 16'h7FFF;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] RDATA_NONE   = 16'h0000;

  // Conversion timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                      1100000, 2116000, 4156000, 8244000};
  localparam int CONV_CYC_DFLT [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};
  localparam int TIMER_W = 20;

  // Averaging: sample counts are powers of two, held as shift amounts.
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int AVG_CNT_W     = 11;
  localparam int SHUNT_ACC_W   = 26;
  localparam int BUS_ACC_W     = 25;

  // Scaling between results.
  localparam int CUR_SHIFT_DFLT = 11;
  localparam int BUS_LSB_UV     = 1250;
  localparam int POWER_RATIO    = 25;
  localparam int POWER_DIV      = POWER_RATIO * 1000000 / BUS_LSB_UV;

  typedef enum logic [1:0] {ST_IDLE, ST_SHUNT, ST_BUS} pmr_state_t;

endpackage

//--- pmr_result_math.sv
/*
  Derived results: current from the shunt result and calibration value,
  and power from current and bus voltage. Both are captured on calc_go.
  Assumes its inputs hold steady in the cycle calc_go is high.
*/
`timescale 1ns/100ps
module pmr_result_math #(
  parameter int CUR_SHIFT = pmr_pkg::CUR_SHIFT_DFLT
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        soft_clr,
  // Operands
  input  wire logic        calc_go,
  input  wire logic [15:0] shunt_avg,
  input  wire logic [14:0] bus_avg,
  input  wire logic [14:0] cal_val,
  // Results
  output logic      [15:0] current_q,
  output logic      [15:0] power_q
);

  logic signed [31:0] cur_full;
  logic signed [31:0] cur_scaled;
  logic        [15:0] cur_sat;
  logic        [16:0] cur_mag;
  logic        [31:0] pw_full;
  logic        [31:0] pw_div;
  logic        [15:0] pw_sat;

  // The signed shunt code times the calibration value gives current.
  always_comb begin
    cur_full   = $signed(shunt_avg) * $signed({1'b0, cal_val});
    cur_scaled = cur_full >>> CUR_SHIFT;
    if (cur_scaled > 32'sd32767) begin
      cur_sat = 16'h7FFF;
    end else if (cur_scaled < -32'sd32768) begin
      cur_sat = 16'h8000;
    end else begin
      cur_sat = cur_scaled[15:0];
    end
  end

  // Power uses the current magnitude, one count being 25 current counts.
  always_comb begin
    cur_mag = cur_sat[15] ? 17'(~{1'b1, cur_sat} + 17'h00001)
                          : {1'b0, cur_sat};
    pw_full = 32'(cur_mag * bus_avg);
    pw_div  = pw_full / 32'(pmr_pkg::POWER_DIV);
    pw_sat  = (pw_div > 32'h0000FFFF) ? 16'hFFFF : pw_div[15:0];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      current_q <= pmr_pkg::RESULT_RESET;
      power_q   <= pmr_pkg::RESULT_RESET;
    end else if (soft_clr) begin
      current_q <= pmr_pkg::RESULT_RESET;
      power_q   <= pmr_pkg::RESULT_RESET;
    end else if (calc_go) begin
      current_q <= cur_sat;
      power_q   <= pw_sat;
    end
  end

endmodule

//--- pmr_checker.sv
/*
  Port checker of the power monitor result register block.
  Assumes it is bound to pmr_result_regs and sees only its ports.
*/
`timescale 1ns/100ps
module pmr_checker #(
  parameter int CONV_CYC [8] = pmr_pkg::CONV_CYC_DFLT,
  parameter int CUR_SHIFT    = pmr_pkg::CUR_SHIFT_DFLT
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Register access
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Front end and status
  input wire logic [15:0] shunt_sample,
  input wire logic [14:0] bus_sample,
  input wire logic        shunt_take,
  input wire logic        bus_take,
  input wire logic        results_update,
  input wire logic        conv_busy
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  chk_unmapped_read: assert property (
    reg_rd && reg_addr > 8'h05 |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned nonzero data");
  chk_bus_msb_zero: assert property (
    reg_rd && reg_addr == pmr_pkg::ADDR_BUS |=> !reg_rdata[15])
    else $error("bus result bit 15 read as one");
  chk_cal_write_read: assert property (
    reg_wr && reg_addr == pmr_pkg::ADDR_CAL ##1 !reg_wr ##1
    reg_rd && reg_addr == pmr_pkg::ADDR_CAL && !reg_wr
    |=> reg_rdata == ($past(reg_wdata, 3) & 16'h7FFF))
    else $error("calibration read back differs from write");
  chk_cfg_fixed_bits: assert property (
    reg_rd && reg_addr == pmr_pkg::ADDR_CONFIG |=> reg_rdata[15:12] == 4'h4)
    else $error("configuration top nibble wrong");
  chk_cfg_write_halt: assert property (
    reg_wr && reg_addr == pmr_pkg::ADDR_CONFIG
    |=> !conv_busy && !shunt_take && !bus_take)
    else $error("conversion not halted by configuration write");
  chk_cfg_restart: assert property (
    reg_wr && reg_addr == pmr_pkg::ADDR_CONFIG && reg_wdata[1:0] != 2'b00
    && !reg_wdata[15] |=> ##1 conv_busy)
    else $error("conversion not restarted after configuration write");
  chk_powerdown_idle: assert property (
    reg_wr && reg_addr == pmr_pkg::ADDR_CONFIG && reg_wdata[1:0] == 2'b00
    && !reg_wdata[15] |=> (!conv_busy && !shunt_take && !bus_take) [*4])
    else $error("activity in power-down mode");
  chk_take_exclusive: assert property (
    !(shunt_take && bus_take))
    else $error("shunt and bus taken in the same cycle");
  chk_update_cause: assert property (
    results_update |-> $past(shunt_take || bus_take))
    else $error("results updated without a preceding take");
  chk_update_single: assert property (
    results_update |=> !results_update)
    else $error("results update lasted more than one cycle");
endmodule

bind pmr_result_regs pmr_checker #(
  .CONV_CYC  (CONV_CYC),
  .CUR_SHIFT (CUR_SHIFT)
) pmr_checker_i (
  .ref_clk        (ref_clk),
  .resetn         (resetn),
  .reg_addr       (reg_addr),
  .reg_wr         (reg_wr),
  .reg_wdata      (reg_wdata),
  .reg_rd         (reg_rd),
  .reg_rdata      (reg_rdata),
  .shunt_sample   (shunt_sample),
  .bus_sample     (bus_sample),
  .shunt_take     (shunt_take),
  .bus_take       (bus_take),
  .results_update (results_update),
  .conv_busy      (conv_busy)
);

//--- pmr_front_model.sv
/*
  Converter front end model: presents alternating sample values.
  Assumes take strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/100ps
module pmr_front_model (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Values presented on alternate takes
  input wire logic [15:0] shunt_a,
  input wire logic [15:0] shunt_b,
  input wire logic [14:0] bus_a,
  input wire logic [14:0] bus_b,
  // Front end handshake
  input wire logic        shunt_take,
  input wire logic        bus_take,
  output logic     [15:0] shunt_sample,
  output logic     [14:0] bus_sample
);
  logic shunt_ph_reg;
  logic bus_ph_reg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      shunt_ph_reg <= 1'b0;
    else if (shunt_take)
      shunt_ph_reg <= !shunt_ph_reg;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      bus_ph_reg <= 1'b0;
    else if (bus_take)
      bus_ph_reg <= !bus_ph_reg;
  end

  // Outside a take the lines carry the inverse, so a stray capture shows.
  always_comb begin
    shunt_sample = shunt_ph_reg ? shunt_b : shunt_a;
    bus_sample   = bus_ph_reg ? bus_b : bus_a;
    if (!shunt_take)
      shunt_sample = ~shunt_sample;
    if (!bus_take)
      bus_sample = ~bus_sample;
  end
endmodule

//--- pmr_result_regs_tb.sv
/*
  Self-checking testbench of the power monitor result register block.
  Assumes the shortened conversion table below and the front end model.
*/
`timescale 1ns/100ps
module pmr_result_regs_tb;
  localparam int CONV_TB [8] = '{3, 4, 5, 6, 7, 8, 9, 10};
  localparam int AVG_N [8]   = '{1, 4, 16, 64, 128, 256, 512, 1024};

  logic        ref_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] shunt_sample;
  logic [14:0] bus_sample;
  logic        shunt_take;
  logic        bus_take;
  logic        results_update;
  logic        conv_busy;
  logic [15:0] sh_a;
  logic [15:0] sh_b;
  logic [14:0] bu_a;
  logic [14:0] bu_b;
  int          fail_count;
  int          check_count;

  pmr_result_regs #(.CONV_CYC(CONV_TB)) pmr_result_regs_i (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shunt_sample(shunt_sample),
    .bus_sample(bus_sample), .shunt_take(shunt_take), .bus_take(bus_take),
    .results_update(results_update), .conv_busy(conv_busy));

  pmr_front_model pmr_front_model_i (
    .ref_clk(ref_clk), .resetn(resetn), .shunt_a(sh_a), .shunt_b(sh_b),
    .bus_a(bu_a), .bus_b(bu_b), .shunt_take(shunt_take),
    .bus_take(bus_take), .shunt_sample(shunt_sample),
    .bus_sample(bus_sample));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rc(string what, logic [7:0] a, logic [15:0] exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    check(what, reg_rdata, exp);
  endtask

  // Waits for the end of a result set and counts shunt takes meanwhile.
  task automatic wait_update(output int takes);
    int n;
    n = 0;
    takes = 0;
    while (results_update !== 1'b1 && n < 40000) begin
      @(negedge ref_clk);
      takes += int'(shunt_take === 1'b1);
      n++;
    end
    check("update seen", {15'h0, results_update}, 16'h0001);
  endtask

  task automatic test_reset();
    rc("config", pmr_pkg::ADDR_CONFIG, 16'h4127);
    rc("shunt", pmr_pkg::ADDR_SHUNT, 16'h0000);
    rc("bus", pmr_pkg::ADDR_BUS, 16'h0000);
    rc("power", pmr_pkg::ADDR_POWER, 16'h0000);
    rc("current", pmr_pkg::ADDR_CURRENT, 16'h0000);
    rc("cal", pmr_pkg::ADDR_CAL, 16'h0000);
    rc("unmapped", 8'h06, 16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_cal_ro();
    wr(pmr_pkg::ADDR_CAL, 16'hFFFF);
    rc("cal msb", pmr_pkg::ADDR_CAL, 16'h7FFF);
    for (int a = 1; a <= 4; a++) begin
      wr(8'(a), 16'hFFFF);
      rc("read-only", 8'(a), 16'h0000);
    end
    $display("test_cal_ro done");
  endtask

  task automatic test_modes();
    int ns;
    int nb;
    logic [15:0] es;
    logic [15:0] eb;
    for (int m = 0; m < 8; m++) begin
      wr(pmr_pkg::ADDR_CONFIG, 16'(m));
      ns = 0;
      nb = 0;
      repeat (40) begin
        @(negedge ref_clk);
        ns += int'(shunt_take === 1'b1);
        nb += int'(bus_take === 1'b1);
      end
      es = m[0] ? (m[2] ? 16'h0002 : 16'h0001) : 16'h0000;
      eb = m[1] ? (m[2] ? 16'h0002 : 16'h0001) : 16'h0000;
      check("shunt takes", 16'(ns > 1 ? 2 : ns), es);
      check("bus takes", 16'(nb > 1 ? 2 : nb), eb);
      check("busy", {15'h0, conv_busy}, {15'h0, m[2] && m[1:0] != 0});
    end
    $display("test_modes done");
  endtask

  task automatic test_conv_times();
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(pmr_pkg::ADDR_CONFIG, 16'((c << 3) | 1));
      n = 0;
      while (shunt_take !== 1'b1 && n < 50) begin
        @(negedge ref_clk);
        n++;
      end
      check("conv cycles", 16'(n), 16'(CONV_TB[c]));
    end
    $display("test_conv_times done");
  endtask

  task automatic test_math();
    int t;
    sh_a = 16'h8300;
    sh_b = 16'h8300;
    bu_a = 15'h2580;
    bu_b = 15'h2580;
    wr(pmr_pkg::ADDR_CAL, 16'h0800);
    wr(pmr_pkg::ADDR_CONFIG, 16'h0003);
    wait_update(t);
    rc("shunt", pmr_pkg::ADDR_SHUNT, 16'h8300);
    rc("bus", pmr_pkg::ADDR_BUS, 16'h2580);
    // Current is -32000 * 2048 >>> 11; power is 32000 * 9600 / 20000.
    rc("current", pmr_pkg::ADDR_CURRENT, 16'h8300);
    rc("power", pmr_pkg::ADDR_POWER, 16'h3C00);
    $display("test_math done");
  endtask

  task automatic test_avg();
    int t;
    sh_a = 16'h0100;
    sh_b = 16'h0300;
    bu_a = 15'h0064;
    bu_b = 15'h012C;
    for (int g = 1; g < 8; g++) begin
      wr(pmr_pkg::ADDR_CONFIG, 16'((g << 9) | 3));
      wait_update(t);
      check("sample count", 16'(t), 16'(AVG_N[g]));
      rc("avg shunt", pmr_pkg::ADDR_SHUNT, 16'h0200);
      rc("avg bus", pmr_pkg::ADDR_BUS, 16'h00C8);
      rc("avg current", pmr_pkg::ADDR_CURRENT, 16'h0200);
      rc("avg power", pmr_pkg::ADDR_POWER, 16'h0005);
    end
    $display("test_avg done");
  endtask

  // Bit 15 of configuration returns every register to its reset value.
  task automatic test_soft_reset();
    wr(pmr_pkg::ADDR_CONFIG, 16'h8000);
    rc("soft config", pmr_pkg::ADDR_CONFIG, 16'h4127);
    rc("soft cal", pmr_pkg::ADDR_CAL, 16'h0000);
    rc("soft current", pmr_pkg::ADDR_CURRENT, 16'h0000);
    $display("test_soft_reset done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    sh_a = 16'h0000;
    sh_b = 16'h0000;
    bu_a = 15'h0000;
    bu_b = 15'h0000;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    test_reset();
    test_cal_ro();
    test_modes();
    test_conv_times();
    test_math();
    test_avg();
    test_soft_reset();
    results();
  end

  // The whole run needs about 13000 cycles; this allows more than four times that.
  initial begin
    #600000;
    fail_count++;
    results();
  end
endmodule
